// ---- oce_cfg.svh ----
// offsets, field positions and reset values for the otg_line_and_supply_control / event enable bank
// assumes: included by bare name from the package, oce_edge_det and oce_regs
`ifndef OCE_CFG_SVH
`define OCE_CFG_SVH
`define OCE_OTG_WR          6'h0A
`define OCE_OTG_SET         6'h0B
`define OCE_OTG_CLR         6'h0C
`define OCE_RISE_WR         6'h0D
`define OCE_RISE_SET        6'h0E
`define OCE_RISE_CLR        6'h0F
`define OCE_FALL_WR         6'h10
`define OCE_FALL_SET        6'h11
`define OCE_FALL_CLR        6'h12
`define OCE_STATUS          6'h13
`define OCE_LATCH           6'h14
`define OCE_OTG_RST         8'h06
`define OCE_EDGE_RST        8'h1F
`define OCE_SRC_MASK        8'h1F
`define OCE_BIT_ID_SAMPLE   0
`define OCE_BIT_DP_PD       1
`define OCE_BIT_DM_PD       2
`define OCE_BIT_DISCHARGE   3
`define OCE_BIT_ID_GROUNDED      4
`define OCE_BIT_SESSION_ENDED    3
`define OCE_BIT_SESS_OK     2
`define OCE_BIT_BUS_OK      1
`define OCE_BIT_HOST_DET    0
`define OCE_NSRC            5
`endif

// ---- oce_edge_det.sv ----
// per-source edge detector with rise/fall enables
// assumes: src is already synchronised to clk
`timescale 1ns/1ps
`include "oce_cfg.svh"
module oce_edge_det (
    input  wire logic                   clk,
    input  wire logic                   rst,
    input  wire logic [`OCE_NSRC-1:0]   src,
    input  wire logic [`OCE_NSRC-1:0]   rise_en,
    input  wire logic [`OCE_NSRC-1:0]   fall_en,
    output logic      [`OCE_NSRC-1:0]   event_hit
);
    logic [`OCE_NSRC-1:0] prev_ff;
    always_ff @(posedge clk) begin
        if (rst) begin
            prev_ff <= '0;
        end else begin
            prev_ff <= src;
        end
    end
    genvar i;
    generate
        for (i = 0; i < `OCE_NSRC; i = i + 1) begin : g_src
            // a masked direction gives nothing
            assign event_hit[i] = (rise_en[i] & src[i] & ~prev_ff[i])
                                | (fall_en[i] & ~src[i] & prev_ff[i]);
        end
    endgenerate
endmodule

// ---- oce_link_model.sv ----
// link controller model: register requests and the discharge handshake
// assumes: requests are one-cycle pulses taken on the rising edge
`timescale 1ns/1ps
module oce_link_model (
    input  wire logic         clk,
    input  wire logic         event_pulse,
    input  wire logic [4:0]   event_bits,
    output oce_pkg::oce_req_t req
);
    initial req = '0;
    task automatic access(input logic w, r, input logic [5:0] a, input logic [7:0] d);
        @(posedge clk) #1;
        req = '{w, r, a, d};
        @(posedge clk) #1;
        req = '0;
    endtask
    // stop once session end has risen or after 20 cycles without it, else the supply may still hold charge
    task automatic discharge(output logic ok);
        access(1'b1, 1'b0, 6'h0B, 8'h08);
        ok = 1'b0;
        for (int n = 0; n < 20 && !ok; n++) begin
            @(posedge clk) #1;
            ok = event_pulse && event_bits[3];
        end
        access(1'b1, 1'b0, 6'h0C, 8'h08);
    endtask
endmodule

// ---- oce_pkg.sv ----
// types shared by the otg_line_and_supply_control / event enable bank
// assumes: oce_cfg.svh holds the offsets and bit positions; the access codes are set here
`include "oce_cfg.svh"
package oce_pkg;
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [5:0] addr;
        logic [7:0] wdata;
    } oce_req_t;
    typedef struct packed {
        logic id_grounded;
        logic session_ended;
        logic session_ok;
        logic bus_power_ok;
        logic host_detach;
    } oce_src_t;
    typedef enum logic [1:0] {
        OCE_ACC_WRITE = 2'b00,
        OCE_ACC_SET   = 2'b01,
        OCE_ACC_CLR   = 2'b10,
        OCE_ACC_NONE  = 2'b11
    } oce_acc_t;
endpackage

// ---- oce_regs.sv ----
// otg_line_and_supply_control low bits, rise/fall event enables, live status and event latch
// assumes: one-cycle reg_req from the ulpi register engine on clk, sources from analog pins
// Function
// - otg_line_and_supply_control bit 2 drives the minus line pull-down and resets to one.
// - otg_line_and_supply_control bit 1 drives the plus line pull-down and resets to one.
// - otg_line_and_supply_control bit 0 enables the id pull-up and id sampling and resets to zero.
// - a zero to one change of a source with its rise enable set raises an event.
// - the rise enables read at 0Dh to 0Fh, write at 0Dh, set at 0Eh and clear at 0Fh.
// - rise enable bits 4..0 map id ground, session end, session ok, bus power ok, host detach; 7..5 reserved zero.
// - a one to zero change of a source with its fall enable set raises an event.
// - the fall enables read at 10h to 12h, write at 10h, set at 11h and clear at 12h.
// - fall enable bits use the same mapping as the rise enables with 7..5 reserved.
// - the status at 13h is read-only and shows the live sources in bits 4..0.
// - latch bits at 14h set on enabled edges and clear on a read or in every cycle that low_power is high.
`timescale 1ns/1ps
`include "oce_cfg.svh"
module oce_regs (
    input  wire logic              clk,
    input  wire logic              rst,
    input  wire oce_pkg::oce_req_t reg_req,
    output logic      [7:0]        reg_rdata,
    input  wire logic              low_power,
    input  wire oce_pkg::oce_src_t src_pin,
    output logic                   minus_line_pulldown_en,
    output logic                   plus_line_pulldown_en,
    output logic                   id_line_sample_en,
    output logic                   bus_power_discharge,
    output logic                   event_pulse,
    output logic      [4:0]        event_bits
);
    logic [7:0]           otg_ff;
    logic [7:0]           rise_ff;
    logic [7:0]           fall_ff;
    logic [7:0]           latch_ff;
    logic [7:0]           rdata_ff;
    logic [4:0]           sync1_ff;
    logic [4:0]           sync2_ff;
    logic [4:0]           src_live;
    logic [4:0]           hit;
    logic [7:0]           nxt_otg;
    logic [7:0]           nxt_rise;
    logic [7:0]           nxt_fall;
    logic [7:0]           nxt_rdata;
    oce_pkg::oce_acc_t    acc_otg;
    oce_pkg::oce_acc_t    acc_rise;
    oce_pkg::oce_acc_t    acc_fall;

    // analog comparator outputs are asynchronous to the ulpi clock
    always_ff @(posedge clk) begin
        if (rst) begin
            sync1_ff <= 5'h00;
            sync2_ff <= 5'h00;
        end else begin
            sync1_ff <= src_pin;
            sync2_ff <= sync1_ff;
        end
    end
    assign src_live = sync2_ff;

    function automatic oce_pkg::oce_acc_t decode(input logic [5:0] a, input logic [5:0] base);
        oce_pkg::oce_acc_t r;
        r = oce_pkg::OCE_ACC_NONE;
        if (a == base) begin
            r = oce_pkg::OCE_ACC_WRITE;
        end else if (a == base + 6'h01) begin
            r = oce_pkg::OCE_ACC_SET;
        end else if (a == base + 6'h02) begin
            r = oce_pkg::OCE_ACC_CLR;
        end
        return r;
    endfunction

    function automatic logic [7:0] apply(input oce_pkg::oce_acc_t acc, input logic [7:0] cur,
                                         input logic [7:0] d, input logic [7:0] keep);
        logic [7:0] r;
        r = cur;
        case (acc)
            oce_pkg::OCE_ACC_WRITE: r = d & keep;
            oce_pkg::OCE_ACC_SET:   r = (cur | d) & keep;
            oce_pkg::OCE_ACC_CLR:   r = cur & ~d;
            default:                r = cur;
        endcase
        return r;
    endfunction

    always_comb begin
        acc_otg  = reg_req.wr ? decode(reg_req.addr, `OCE_OTG_WR) : oce_pkg::OCE_ACC_NONE;
        acc_rise = reg_req.wr ? decode(reg_req.addr, `OCE_RISE_WR) : oce_pkg::OCE_ACC_NONE;
        acc_fall = reg_req.wr ? decode(reg_req.addr, `OCE_FALL_WR) : oce_pkg::OCE_ACC_NONE;
        nxt_otg  = apply(acc_otg, otg_ff, reg_req.wdata, 8'hFF);
        // reserved enable bits stay zero
        nxt_rise = apply(acc_rise, rise_ff, reg_req.wdata, `OCE_SRC_MASK);
        nxt_fall = apply(acc_fall, fall_ff, reg_req.wdata, `OCE_SRC_MASK);
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            otg_ff <= `OCE_OTG_RST;
        end else begin
            otg_ff <= nxt_otg;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            rise_ff <= `OCE_EDGE_RST;
            fall_ff <= `OCE_EDGE_RST;
        end else begin
            rise_ff <= nxt_rise;
            fall_ff <= nxt_fall;
        end
    end

    oce_edge_det u_edge (
        .clk       (clk),
        .rst       (rst),
        .src       (src_live),
        .rise_en   (rise_ff[4:0]),
        .fall_en   (fall_ff[4:0]),
        .event_hit (hit)
    );

    // a new edge in the read cycle survives the clear, so no event is lost
    always_ff @(posedge clk) begin
        if (rst) begin
            latch_ff <= 8'h00;
        end else if ((reg_req.rd && reg_req.addr == `OCE_LATCH) || low_power) begin
            latch_ff <= {3'h0, hit};
        end else begin
            latch_ff <= latch_ff | {3'h0, hit};
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            event_pulse <= 1'b0;
            event_bits  <= 5'h00;
        end else begin
            event_pulse <= |hit;
            event_bits  <= src_live;
        end
    end

    always_comb begin
        nxt_rdata = 8'h00;
        case (reg_req.addr)
            `OCE_OTG_WR, `OCE_OTG_SET, `OCE_OTG_CLR:    nxt_rdata = otg_ff;
            `OCE_RISE_WR, `OCE_RISE_SET, `OCE_RISE_CLR: nxt_rdata = rise_ff;
            `OCE_FALL_WR, `OCE_FALL_SET, `OCE_FALL_CLR: nxt_rdata = fall_ff;
            // undefined upper bits read as zero
            `OCE_STATUS:                                nxt_rdata = {3'h0, src_live};
            `OCE_LATCH:                                 nxt_rdata = latch_ff;
            default:                                    nxt_rdata = 8'h00;
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            rdata_ff <= 8'h00;
        end else if (reg_req.rd) begin
            rdata_ff <= nxt_rdata;
        end
    end
    assign reg_rdata = rdata_ff;

    assign minus_line_pulldown_en = otg_ff[`OCE_BIT_DM_PD];
    assign plus_line_pulldown_en  = otg_ff[`OCE_BIT_DP_PD];
    assign id_line_sample_en      = otg_ff[`OCE_BIT_ID_SAMPLE];
    // discharge stays on until the link clears it
    assign bus_power_discharge    = otg_ff[`OCE_BIT_DISCHARGE];
endmodule

// ---- oce_regs_properties.sv ----
// assertions for the otg_line_and_supply_control / event enable bank
// assumes: bound to oce_regs, one clock domain
`timescale 1ns/1ps
module oce_regs_properties (
    input wire logic              clk,
    input wire logic              rst,
    input wire oce_pkg::oce_req_t reg_req,
    input wire logic [7:0]        reg_rdata,
    input wire logic              low_power,
    input wire logic              minus_line_pulldown_en,
    input wire logic              plus_line_pulldown_en,
    input wire logic              id_line_sample_en,
    input wire logic              event_pulse
);
    logic [2:0] pins;
    logic [2:0] wd;
    logic       wr;
    logic       rd;
    logic [5:0] ad;
    assign pins = {minus_line_pulldown_en, plus_line_pulldown_en, id_line_sample_en};
    assign wd = reg_req.wdata[2:0];
    assign wr = reg_req.wr;
    assign rd = reg_req.rd;
    assign ad = reg_req.addr;
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    reset_values_a: assert property ($past(rst) |-> pins == 3'h6)
        else $error("otg_line_and_supply_control reset value wrong");
    otg_write_a: assert property ($past(wr && ad == 6'h0A) |-> pins == $past(wd))
        else $error("otg_line_and_supply_control write not applied");
    otg_set_a: assert property ($past(wr && ad == 6'h0B) |-> pins == ($past(pins) | $past(wd)))
        else $error("otg_line_and_supply_control set wrong");
    otg_clear_a: assert property ($past(wr && ad == 6'h0C) |-> pins == ($past(pins) & ~$past(wd)))
        else $error("otg_line_and_supply_control clear wrong");
    rise_reserved_a: assert property ($past(rd && ad >= 6'h0D && ad <= 6'h0F) |-> reg_rdata[7:5] == 3'h0)
        else $error("rise enable reserved bits set");
    fall_reserved_a: assert property ($past(rd && ad >= 6'h10 && ad <= 6'h12) |-> reg_rdata[7:5] == 3'h0)
        else $error("fall enable reserved bits set");
    status_reserved_a: assert property ($past(rd && ad == 6'h13) |-> reg_rdata[7:5] == 3'h0)
        else $error("status reserved bits set");
    latch_clear_a: assert property ($past(rd && ad == 6'h14) && $past(low_power, 2) && !$past(event_pulse)
        && !event_pulse |-> reg_rdata == 8'h00)
        else $error("latch not cleared in low power");
endmodule
bind oce_regs oce_regs_properties oce_regs_properties_inst (.clk, .rst, .reg_req, .reg_rdata, .low_power,
    .minus_line_pulldown_en, .plus_line_pulldown_en, .id_line_sample_en, .event_pulse);

// ---- oce_regs_tb.sv ----
// self-checking bench for the otg_line_and_supply_control / event enable bank
// assumes: link model issues requests, bench drives sources and low power
`timescale 1ns/1ps
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin fail_count++; $display("[ERR] %s exp %h got %h", n, e, g); end end
module oce_regs_tb;
    logic              clk, rst, low_power, event_pulse, m_pd, p_pd, id_en, dis, ok;
    oce_pkg::oce_src_t src_pin;
    oce_pkg::oce_req_t reg_req;
    logic [7:0]        reg_rdata, d, e, r, f, mk;
    logic [4:0]        event_bits, old;
    logic [5:0]        base [3] = '{6'h0A, 6'h0D, 6'h10};
    int                fail_count, checked, seed = 32'h4194;
    oce_regs oce_regs_inst (.clk(clk), .rst(rst), .reg_req(reg_req), .reg_rdata(reg_rdata), .low_power(low_power),
        .src_pin(src_pin), .minus_line_pulldown_en(m_pd), .plus_line_pulldown_en(p_pd), .id_line_sample_en(id_en),
        .bus_power_discharge(dis), .event_pulse(event_pulse), .event_bits(event_bits));
    oce_link_model oce_link_model_inst (.clk(clk), .event_pulse(event_pulse), .event_bits(event_bits), .req(reg_req));
    task automatic chk_rd(input logic [5:0] a, input logic [7:0] x);
        oce_link_model_inst.access(1'b0, 1'b1, a, 8'h00);
        `CHK("rdata", x, reg_rdata)
    endtask
    task automatic wr(input logic [5:0] a, input logic [7:0] v);
        oce_link_model_inst.access(1'b1, 1'b0, a, v);
    endtask
    function automatic logic [7:0] hits(input logic [4:0] o, n, input logic [7:0] re, fe);
        return {3'h0, (n & ~o & re[4:0]) | (o & ~n & fe[4:0])};
    endfunction
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    initial begin
        clk = 0;
        forever #20 clk = ~clk;
    end
    initial begin
        #2000000 fail_count++;
        print_verdict();
    end
    initial begin
        rst = 1; low_power = 0; src_pin = '0;
        repeat (4) @(posedge clk);
        #1 rst = 0;
        `CHK("pulldowns", 3'h6, {m_pd, p_pd, id_en})
        chk_rd(6'h0D, 8'h1F);
        chk_rd(6'h12, 8'h1F);
        for (int i = 0; i < 3; i++) begin
            mk = (i == 0) ? 8'hFF : 8'h1F;
            e = 8'($random(seed)); wr(base[i], e); e &= mk;
            chk_rd(base[i] + 6'h2, e);
            d = 8'($random(seed)); wr(base[i] + 6'h1, d); e |= d & mk;
            chk_rd(base[i] + 6'h1, e);
            d = 8'($random(seed)); wr(base[i] + 6'h2, d); e &= ~d;
            chk_rd(base[i], e);
            if (i == 0) `CHK("otg_pins", e[2:0], {m_pd, p_pd, id_en})
        end
        $display("test registers done");
        src_pin = 5'($random(seed)); wr(6'h13, 8'hFF);
        repeat (4) @(posedge clk);
        chk_rd(6'h13, {3'h0, src_pin});
        chk_rd(6'h3A, 8'h00);
        $display("test status done");
        for (int k = 0; k < 24; k++) begin
            r = 8'($random(seed)); f = 8'($random(seed));
            wr(6'h0D, r); wr(6'h10, f);
            repeat (6) @(posedge clk);
            oce_link_model_inst.access(1'b0, 1'b1, 6'h14, 8'h00);
            old = src_pin; src_pin = 5'($random(seed)); low_power = (k % 4 == 3);
            repeat (6) @(posedge clk);
            chk_rd(6'h14, low_power ? 8'h00 : hits(old, src_pin, r, f));
            low_power = 0;
        end
        $display("test events done");
        src_pin = '0; wr(6'h0D, 8'h1F);
        repeat (6) @(posedge clk);
        fork
            oce_link_model_inst.discharge(ok);
            begin repeat (4) @(posedge clk); #1 src_pin.session_ended = 1'b1; end
        join
        `CHK("discharge_done", 2'h2, {ok, dis})
        $display("test discharge done");
        print_verdict();
    end
endmodule
